//--- pkg/nmbr_defines.vh
`ifndef NMBR_DEFINES_VH
`define NMBR_DEFINES_VH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define NMBR_OP_DUAL_OUT 8'h3B
`define NMBR_OP_DUAL_OUT4 8'h3C
`define NMBR_OP_QUAD_OUT 8'h6B
`define NMBR_OP_QUAD_OUT4 8'h6C
`define NMBR_OP_DUAL_IO 8'hBB
`define NMBR_OP_DUAL_IO4 8'hBC
`define NMBR_OP_QUAD_IO 8'hEB
// ----------------------------------------
// Framing, in bits
// ----------------------------------------
`define NMBR_COL_BITS 7'h10
`define NMBR_DUMMY_BUF 7'h08
`define NMBR_DUMMY_CONT 7'h20
`define NMBR_DUMMY4_BUF 7'h18
`define NMBR_DUMMY4_CONT 7'h28
// ----------------------------------------
// Buffer geometry
// ----------------------------------------
`define NMBR_BUF_LAST 16'h083F
`define NMBR_PAGE_W 16
`define NMBR_FIFO_DEPTH 16
`define NMBR_FIFO_AW 4
`endif

//--- src/nmbr_fifo.v
`timescale 1ns/100ps
`include "nmbr_defines.vh"
module nmbr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = `NMBR_FIFO_DEPTH,
  parameter AW = `NMBR_FIFO_AW
) (
  input wire clock,
  input wire rst,
  input wire flush,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wrPtr_r;
  reg [AW:0] rdPtr_r;
  wire [AW:0] fill = wrPtr_r - rdPtr_r;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;
  assign inReady = (fill != DEPTH[AW:0]);
  assign outValid = (fill != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_r[AW-1:0]];
  always @(posedge clock) begin
    if (push) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end
  always @(posedge clock) begin
    if (rst || flush) begin
      wrPtr_r <= {(AW+1){1'b0}};
      rdPtr_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
    end
  end
endmodule

//--- src/nmbr_read_ctrl.v
`timescale 1ns/100ps
`include "nmbr_defines.vh"
module nmbr_read_ctrl (
  input wire clock,
  input wire rst,
  input wire chipSelectN,
  input wire serialClock,
  input wire [3:0] dataLineIn,
  output reg [3:0] dataLineOut,
  output reg [3:0] dataLineOe,
  input wire bufferMode,
  input wire writeProtectMode,
  input wire [`NMBR_PAGE_W-1:0] pageIndex,
  output wire fetchValid,
  input wire fetchReady,
  output wire [`NMBR_PAGE_W-1:0] fetchPage,
  output wire [15:0] fetchColumn,
  input wire dataValid,
  output wire dataReady,
  input wire [7:0] dataByte,
  output wire busy
);
  // ----------------------------------------
  // States and helpers
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_OPCODE = 3'h1;
  localparam ST_COLUMN = 3'h2;
  localparam ST_DUMMY = 3'h3;
  localparam ST_DATA = 3'h4;
  localparam ST_IGNORE = 3'h5;
  localparam ST_FLOAT = 3'h6;

  // Lanes used by opcode: [1:0] input width code, [3:2] output width code
  function [3:0] opDecode;
    input [7:0] op;
    input wpm;
    begin
      case (op)
        `NMBR_OP_DUAL_OUT: opDecode = 4'h5;
        `NMBR_OP_DUAL_OUT4: opDecode = 4'h5;
        `NMBR_OP_QUAD_OUT: opDecode = wpm ? 4'h0 : 4'h9;
        `NMBR_OP_QUAD_OUT4: opDecode = wpm ? 4'h0 : 4'h9;
        `NMBR_OP_DUAL_IO: opDecode = 4'h6;
        `NMBR_OP_DUAL_IO4: opDecode = 4'h6;
        `NMBR_OP_QUAD_IO: opDecode = wpm ? 4'h0 : 4'hB;
        default: opDecode = 4'h0;
      endcase
    end
  endfunction

  function [6:0] widthBits;
    input [1:0] code;
    begin
      case (code)
        2'h1: widthBits = 7'h01;
        2'h2: widthBits = 7'h02;
        default: widthBits = 7'h04;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [2:0] csSync_r;
  reg [2:0] sckSync_r;
  reg [2:0] dinSync0_r;
  reg [2:0] dinSync1_r;
  reg [2:0] dinSync2_r;
  reg [2:0] dinSync3_r;
  reg csLevel_r;
  reg sckLevel_r;
  always @(posedge clock) begin
    if (rst) begin
      csSync_r <= 3'h7;
      sckSync_r <= 3'h0;
      dinSync0_r <= 3'h0;
      dinSync1_r <= 3'h0;
      dinSync2_r <= 3'h0;
      dinSync3_r <= 3'h0;
      csLevel_r <= 1'b1;
      sckLevel_r <= 1'b0;
    end else begin
      csSync_r <= {csSync_r[1:0], chipSelectN};
      sckSync_r <= {sckSync_r[1:0], serialClock};
      dinSync0_r <= {dinSync0_r[1:0], dataLineIn[0]};
      dinSync1_r <= {dinSync1_r[1:0], dataLineIn[1]};
      dinSync2_r <= {dinSync2_r[1:0], dataLineIn[2]};
      dinSync3_r <= {dinSync3_r[1:0], dataLineIn[3]};
      if (csSync_r[1] == csSync_r[2]) begin
        csLevel_r <= csSync_r[2];
      end
      if (sckSync_r[1] == sckSync_r[2]) begin
        sckLevel_r <= sckSync_r[2];
      end
    end
  end
  wire [3:0] dinNow = {dinSync3_r[2], dinSync2_r[2], dinSync1_r[2], dinSync0_r[2]};
  wire sckAgree = (sckSync_r[1] == sckSync_r[2]);
  wire sckRise = sckAgree && sckSync_r[2] && !sckLevel_r;
  wire sckFall = sckAgree && !sckSync_r[2] && sckLevel_r;
  wire csActive = !csLevel_r;

  // ----------------------------------------
  // Command state
  // ----------------------------------------
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [6:0] bitCnt_r;
  reg [7:0] opcode_r;
  reg [15:0] column_r;
  reg [1:0] inWidth_r;
  reg [1:0] outWidth_r;
  reg longAddr_r;
  reg [6:0] dummyBits_r;
  reg fetchPending_r;
  reg [`NMBR_PAGE_W-1:0] page_r;
  reg [15:0] addr_r;
  reg [7:0] shift_r;
  reg [3:0] slotCnt_r;
  reg haveByte_r;
  reg firstOut_r;

  wire [3:0] decNow = opDecode({opcode_r[6:0], dinNow[0]}, writeProtectMode);
  wire [6:0] inStep = widthBits(inWidth_r);
  wire [6:0] outStep = widthBits(outWidth_r);
  wire [7:0] slotsPerByte = (outWidth_r == 2'h2) ? 8'h02 : 8'h04;

  // Frame end always wins: drive stops and fetch request is dropped
  wire frameEnd = !csActive;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (csActive) begin
          state_nxt = ST_OPCODE;
        end
      end
      ST_OPCODE: begin
        if (sckRise && bitCnt_r == 7'h07) begin
          state_nxt = (decNow == 4'h0) ? ST_IGNORE : ST_COLUMN;
        end
      end
      ST_COLUMN: begin
        if (sckRise && bitCnt_r + inStep >= `NMBR_COL_BITS) begin
          state_nxt = ST_DUMMY;
        end
      end
      ST_DUMMY: begin
        if (sckRise && bitCnt_r + inStep >= dummyBits_r) begin
          state_nxt = ST_DATA;
        end
      end
      ST_DATA: begin
        if (bufferMode && haveByte_r == 1'b0 && addr_r > `NMBR_BUF_LAST && sckFall) begin
          state_nxt = ST_FLOAT;
        end
      end
      ST_IGNORE: state_nxt = ST_IGNORE;
      ST_FLOAT: state_nxt = ST_FLOAT;
      default: state_nxt = ST_IDLE;
    endcase
    if (frameEnd) begin
      state_nxt = ST_IDLE;
    end
  end

  // ----------------------------------------
  // Byte fetch path through the FIFO
  // ----------------------------------------
  wire fifoInReady;
  wire fifoOutValid;
  wire [7:0] fifoOutData;
  wire takeByte = fifoOutValid && !haveByte_r && state_r == ST_DATA;
  assign fetchValid = fetchPending_r && fifoInReady;
  assign fetchPage = page_r;
  assign fetchColumn = addr_r;
  assign dataReady = fifoInReady;
  assign busy = csActive;

  nmbr_fifo #(
    .WIDTH(8),
    .DEPTH(`NMBR_FIFO_DEPTH),
    .AW(`NMBR_FIFO_AW)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .flush(frameEnd),
    .inValid(dataValid),
    .inReady(fifoInReady),
    .inData(dataByte),
    .outValid(fifoOutValid),
    .outReady(takeByte),
    .outData(fifoOutData)
  );

  always @(posedge clock) begin
    if (rst) begin
      state_r <= ST_IDLE;
      bitCnt_r <= 7'h00;
      opcode_r <= 8'h00;
      column_r <= 16'h0000;
      inWidth_r <= 2'h1;
      outWidth_r <= 2'h1;
      longAddr_r <= 1'b0;
      dummyBits_r <= `NMBR_DUMMY_BUF;
      fetchPending_r <= 1'b0;
      page_r <= {`NMBR_PAGE_W{1'b0}};
      addr_r <= 16'h0000;
      shift_r <= 8'h00;
      slotCnt_r <= 4'h0;
      haveByte_r <= 1'b0;
      firstOut_r <= 1'b0;
      dataLineOut <= 4'h0;
      dataLineOe <= 4'h0;
    end else begin
      state_r <= state_nxt;
      if (state_r != state_nxt) begin
        bitCnt_r <= 7'h00;
      end
      case (state_r)
        ST_IDLE: begin
          inWidth_r <= 2'h1;
          haveByte_r <= 1'b0;
          fetchPending_r <= 1'b0;
        end
        ST_OPCODE: begin
          if (sckRise) begin
            opcode_r <= {opcode_r[6:0], dinNow[0]};
            if (state_nxt == ST_OPCODE) begin
              bitCnt_r <= bitCnt_r + 7'h01;
            end
            if (bitCnt_r == 7'h07) begin
              inWidth_r <= decNow[1:0];
              outWidth_r <= decNow[3:2];
              longAddr_r <= opcode_r[1];
            end
          end
        end
        ST_COLUMN: begin
          if (sckRise) begin
            if (state_nxt == ST_COLUMN) begin
              bitCnt_r <= bitCnt_r + inStep;
            end
            case (inWidth_r)
              2'h2: column_r <= {column_r[13:0], dinNow[1:0]};
              2'h1: column_r <= {column_r[14:0], dinNow[0]};
              default: column_r <= {column_r[11:0], dinNow};
            endcase
            if (longAddr_r) begin
              dummyBits_r <= bufferMode ? `NMBR_DUMMY4_BUF : `NMBR_DUMMY4_CONT;
            end else begin
              dummyBits_r <= bufferMode ? `NMBR_DUMMY_BUF : `NMBR_DUMMY_CONT;
            end
          end
        end
        ST_DUMMY: begin
          if (sckRise && state_nxt == ST_DUMMY) begin
            bitCnt_r <= bitCnt_r + inStep;
          end
          if (state_nxt == ST_DATA) begin
            addr_r <= bufferMode ? column_r : 16'h0000;
            page_r <= pageIndex;
            fetchPending_r <= 1'b1;
            slotCnt_r <= 4'h0;
            firstOut_r <= 1'b1;
          end
        end
        ST_DATA: begin
          if (fetchValid && fetchReady) begin
            fetchPending_r <= 1'b0;
          end
          if (takeByte) begin
            shift_r <= fifoOutData;
            haveByte_r <= 1'b1;
            if (addr_r == `NMBR_BUF_LAST && !bufferMode) begin
              addr_r <= 16'h0000;
              page_r <= page_r + 1'b1;
            end else begin
              addr_r <= addr_r + 16'h0001;
            end
            if (!(bufferMode && addr_r == `NMBR_BUF_LAST)) begin
              fetchPending_r <= 1'b1;
            end
          end
          if (haveByte_r && (sckFall || firstOut_r)) begin
            firstOut_r <= 1'b0;
            dataLineOe <= (outWidth_r == 2'h2) ? 4'hF : 4'h3;
            case (outWidth_r)
              2'h2: begin
                dataLineOut <= shift_r[7:4];
                shift_r <= {shift_r[3:0], 4'h0};
              end
              default: begin
                dataLineOut <= {2'h0, shift_r[7:6]};
                shift_r <= {shift_r[5:0], 2'h0};
              end
            endcase
            if ({4'h0, slotCnt_r} + 8'h01 == slotsPerByte) begin
              slotCnt_r <= 4'h0;
              haveByte_r <= 1'b0;
            end else begin
              slotCnt_r <= slotCnt_r + 4'h1;
            end
          end
        end
        default: begin
          dataLineOe <= 4'h0;
        end
      endcase
      if (frameEnd) begin
        dataLineOe <= 4'h0;
        fetchPending_r <= 1'b0;
      end
    end
  end
endmodule

//--- tb/nmbr_read_props.sv
`timescale 1ns/100ps
// ----------
// Port checks
// ----------
module nmbr_read_props (
  input wire clock,
  input wire rst,
  input wire chipSelectN,
  input wire writeProtectMode,
  input wire [3:0] dataLineOe,
  input wire fetchValid,
  input wire fetchReady,
  input wire [15:0] fetchPage,
  input wire [15:0] fetchColumn,
  input wire busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_reset_quiet: assert property (
    disable iff (1'h0) rst |=> dataLineOe == 4'h0 && !fetchValid) else $error("drive in reset");
  a_cs_release: assert property (
    chipSelectN [*6] |-> dataLineOe == 4'h0) else $error("drive after frame");
  a_wp_quad: assert property (
    writeProtectMode |-> !dataLineOe[2]) else $error("quad drive while locked");
  a_lane_set: assert property (
    dataLineOe inside {4'h0, 4'h3, 4'hF}) else $error("odd lane set");
  a_oe_frame: assert property (
    |dataLineOe |-> busy || $past(busy)) else $error("drive outside frame");
  a_fetch_hold: assert property (
    fetchValid && !fetchReady && !chipSelectN |=> fetchValid && $stable(fetchPage)
      && $stable(fetchColumn)) else $error("fetch dropped");
  a_drive_start: assert property (
    $rose(|dataLineOe) |-> !chipSelectN) else $error("drive start unframed");
  a_fetch_frame: assert property (
    fetchValid |-> busy || $past(busy)) else $error("fetch outside frame");
endmodule
bind nmbr_read_ctrl nmbr_read_props nmbr_read_props_i (.clock(clock), .rst(rst),
  .chipSelectN(chipSelectN), .writeProtectMode(writeProtectMode), .dataLineOe(dataLineOe),
  .fetchValid(fetchValid), .fetchReady(fetchReady), .fetchPage(fetchPage),
  .fetchColumn(fetchColumn), .busy(busy));

//--- tb/nmbr_store_model.sv
`timescale 1ns/100ps
// ----------
// Buffer store
// ----------
module nmbr_store_model (
  input wire clock,
  input wire rst,
  input wire slow,
  input wire fetchValid,
  output logic fetchReady,
  input wire [15:0] fetchPage,
  input wire [15:0] fetchColumn,
  output logic dataValid,
  input wire dataReady,
  output logic [7:0] dataByte
);
  logic [1:0] waitR;
  logic [7:0] held;
  logic pend;
  always @(posedge clock) begin
    if (rst) begin
      fetchReady <= 1'h1;
      dataValid <= 1'h0;
      dataByte <= 8'h00;
      waitR <= 2'h0;
      held <= 8'h00;
      pend <= 1'h0;
    end else if (fetchValid && fetchReady) begin
      fetchReady <= 1'h0;
      pend <= 1'h1;
      waitR <= slow ? 2'h3 : 2'h0;
      held <= fetchColumn[7:0] ^ {fetchColumn[11:8], fetchPage[3:0]};
    end else if (pend && !dataValid) begin
      if (waitR == 2'h0) begin
        dataValid <= 1'h1;
        dataByte <= held;
      end else begin
        waitR <= waitR - 2'h1;
      end
    end else if (dataValid && dataReady) begin
      dataValid <= 1'h0;
      pend <= 1'h0;
      // A slow store stays busy a while, so a request must wait for ready
      fetchReady <= !slow;
      waitR <= slow ? 2'h3 : 2'h0;
      dataByte <= ~dataByte;
    end else if (!pend && !fetchReady) begin
      if (waitR == 2'h0) begin
        fetchReady <= 1'h1;
      end else begin
        waitR <= waitR - 2'h1;
      end
    end
  end
endmodule

//--- tb/nmbr_read_ctrl_tb_top.sv
`timescale 1ns/100ps
`include "nmbr_defines.vh"
// ----------
// Bench
// ----------
module nmbr_read_ctrl_tb_top;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic chipSelectN = 1'h1;
  logic serialClock = 1'h0;
  logic bufferMode = 1'h1;
  logic writeProtectMode = 1'h0;
  logic slow = 1'h0;
  logic [3:0] hostLines = 4'h0;
  logic [15:0] pageIndex = 16'h0000;
  logic [31:0] seed = 32'h00017A91;
  int n_errors = 0;
  int total_checks = 0;
  wire [3:0] dataLineIn;
  wire [3:0] dataLineOut;
  wire [3:0] dataLineOe;
  wire fetchValid, fetchReady, dataValid, dataReady, busy;
  wire [15:0] fetchPage;
  wire [15:0] fetchColumn;
  wire [7:0] dataByte;
  assign dataLineIn = (dataLineOe & dataLineOut) | (~dataLineOe & hostLines);
  always #12.5 clock = ~clock;
  nmbr_read_ctrl nmbr_read_ctrl_i (.clock(clock), .rst(rst), .chipSelectN(chipSelectN),
    .serialClock(serialClock), .dataLineIn(dataLineIn), .dataLineOut(dataLineOut),
    .dataLineOe(dataLineOe), .bufferMode(bufferMode), .writeProtectMode(writeProtectMode),
    .pageIndex(pageIndex), .fetchValid(fetchValid), .fetchReady(fetchReady),
    .fetchPage(fetchPage), .fetchColumn(fetchColumn), .dataValid(dataValid),
    .dataReady(dataReady), .dataByte(dataByte), .busy(busy));
  nmbr_store_model nmbr_store_model_i (.clock(clock), .rst(rst), .slow(slow),
    .fetchValid(fetchValid), .fetchReady(fetchReady), .fetchPage(fetchPage),
    .fetchColumn(fetchColumn), .dataValid(dataValid), .dataReady(dataReady),
    .dataByte(dataByte));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] expByte(input logic [15:0] pg, input logic [15:0] col);
    return col[7:0] ^ {col[11:8], pg[3:0]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // One link clock: data set while low, sampled before the fall
  task automatic tick(input logic [3:0] d, output logic [3:0] oe, output logic [3:0] q);
    hostLines = d;
    repeat (4) @(posedge clock);
    #1 serialClock = 1'h1;
    repeat (4) @(posedge clock);
    #1 oe = dataLineOe;
    q = dataLineOut;
    serialClock = 1'h0;
  endtask
  task automatic sendBits(input logic [39:0] v, input int n, input int w);
    logic [3:0] oe;
    logic [3:0] q;
    for (int i = n - w; i >= 0; i -= w) begin
      tick(4'(v >> i) & 4'((1 << w) - 1), oe, q);
      check(oe, 4'h0);
    end
  endtask
  task automatic frame(input logic [7:0] op, input logic [15:0] col, input int nb);
    logic [3:0] oe;
    logic [3:0] q;
    logic [3:0] eo;
    logic [15:0] pg;
    logic [15:0] a;
    logic [7:0] b;
    int aw;
    int ow;
    int dm;
    bit quad;
    quad = op == 8'h6B || op == 8'h6C || op == 8'hEB;
    aw = op == 8'hEB ? 4 : (op[7:4] == 4'hB ? 2 : 1);
    ow = quad ? 4 : 2;
    dm = op[3:0] == 4'hC ? (bufferMode ? 24 : 40) : (bufferMode ? 8 : 32);
    eo = quad ? 4'hF : 4'h3;
    if (writeProtectMode && quad) eo = 4'h0;
    if (!(op[3:0] inside {4'hB, 4'hC})) eo = 4'h0;
    pg = pageIndex;
    a = bufferMode ? col : 16'h0000;
    chipSelectN = 1'h0;
    repeat (4) @(posedge clock);
    #1 sendBits({32'h0, op}, 8, 1);
    check(busy, 1'h1);
    sendBits({24'h0, col}, 16, aw);
    sendBits(40'(xs()), dm, aw);
    for (int k = 0; k < nb; k++) begin
      if (a == 16'h0840) begin
        if (bufferMode) eo = 4'h0;
        a = 16'h0000;
        pg++;
      end
      b = expByte(pg, a);
      for (int s = 0; s < 8 / ow; s++) begin
        tick(4'(xs()), oe, q);
        check(oe, eo);
        if (eo != 4'h0) check(q & eo, 4'(b >> (8 - ow * (s + 1))) & eo);
      end
      a++;
    end
    chipSelectN = 1'h1;
    repeat (8) @(posedge clock);
    #1 check(dataLineOe, 4'h0);
    check(busy, 1'h0);
  endtask
  initial begin
    logic [7:0] ops [7];
    ops = '{`NMBR_OP_DUAL_OUT, `NMBR_OP_DUAL_OUT4, `NMBR_OP_QUAD_OUT, `NMBR_OP_QUAD_OUT4,
      `NMBR_OP_DUAL_IO, `NMBR_OP_DUAL_IO4, `NMBR_OP_QUAD_IO};
    repeat (16) @(posedge clock);
    #1 rst = 1'h0;
    repeat (4) @(posedge clock);
    #1;
    for (int w = 0; w < 2; w++) begin
      foreach (ops[i]) begin
        for (int m = 0; m < 2; m++) begin
          writeProtectMode = w[0];
          bufferMode = m[0];
          slow = 1'(xs());
          pageIndex = 16'(xs());
          frame(ops[i], 16'(xs() % 32'h00000840), 3);
        end
      end
    end
    writeProtectMode = 1'h0;
    bufferMode = 1'h1;
    slow = 1'h1;
    frame(`NMBR_OP_DUAL_IO, 16'h083E, 4);
    frame(8'h5A, 16'h0010, 1);
    frame(`NMBR_OP_DUAL_OUT, 16'h0000, 0);
    rst = 1'h1;
    repeat (2) @(posedge clock);
    #1 rst = 1'h0;
    repeat (4) @(posedge clock);
    #1 bufferMode = 1'h0;
    frame(`NMBR_OP_QUAD_IO, 16'h0123, 2114);
    report_and_stop();
  end
  initial begin
    repeat (90000) @(posedge clock);
    n_errors++;
    report_and_stop();
  end
endmodule
